// ==== sim/standby_wake_reset_flags_bench.sv ====
// bench for the standby wake and reset cause block
// assumes the far side model drives pins and reset events
`include "wake_params.svh"
`timescale 1ns/1ps
`default_nettype none
module standby_wake_reset_flags_bench;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [`ADDR_W-1:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic low_voltage_wake_i;
  logic [3:0] ext_wake_i;
  logic calendar_wake_i;
  logic watchdog_reset_i;
  logic system_reset_done_i;
  logic [`NUM_SRC-1:0] wake_request_o;
  logic irq_o;
  logic system_reset_request_o;
  logic active_vector_clear_o;
  logic [5:0] pin_level = 6'h20;
  logic wdt_cmd = 1'b0;
  logic slow = 1'b1;
  logic [31:0] rd_val;
  logic [31:0] shadow_a = 32'h2020_2020;
  logic [31:0] shadow_b = 32'h2020_2020;
  int err_total = 0;
  int total_checks = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  standby_wake_reset_flags DUT (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .low_voltage_wake_i(low_voltage_wake_i),
    .ext_wake_i(ext_wake_i), .calendar_wake_i(calendar_wake_i),
    .watchdog_reset_i(watchdog_reset_i),
    .system_reset_done_i(system_reset_done_i),
    .wake_request_o(wake_request_o), .irq_o(irq_o),
    .system_reset_request_o(system_reset_request_o),
    .active_vector_clear_o(active_vector_clear_o));

  wake_far_side u_far (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .pin_level_i(pin_level), .wdt_cmd_i(wdt_cmd), .slow_i(slow),
    .system_reset_request_i(system_reset_request_o),
    .low_voltage_wake_o(low_voltage_wake_i), .ext_wake_o(ext_wake_i),
    .calendar_wake_o(calendar_wake_i),
    .watchdog_reset_o(watchdog_reset_i),
    .system_reset_done_o(system_reset_done_i));

  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
    chk(rd_val, exp, "read");
  endtask : rd_chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc
  task automatic pin(input int s, input logic v);
    @(posedge sys_clk_i);
    pin_level[s] <= v;
    #1;
  endtask : pin
  // bounded wait, the sync chain plus detection takes a few cycles
  task automatic wait_req(input int s, input logic v);
    for (int k = 0; k < 12 && wake_request_o[s] !== v; k++) cyc(1);
  endtask : wait_req
  task automatic lane_wr(input int s, input logic [7:0] v);
    if (s < 4) begin
      shadow_a[s*8 +: 8] = v;
      wr(`OFS_MODE_A, shadow_a);
    end else begin
      shadow_b[(s-4)*8 +: 8] = v;
      wr(`OFS_MODE_B, shadow_b);
    end
  endtask : lane_wr
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  initial begin
    #200000;
    err_total++;
    finish_test();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic act;
    logic [2:0] code;
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    rd_chk(`OFS_MODE_A, 32'h2020_2020);
    rd_chk(`OFS_MODE_B, 32'h2020_2020);
    rd_chk(`OFS_CLEAR, 32'h0);
    rd_chk(`OFS_RST_FLAGS, 32'h1);
    rd_chk(`OFS_CORE_CTRL, 32'hfa05_0000);
    rd_chk(8'h1c, 32'h0);
    chk(wake_request_o, 32'h0, "reset req");
    $display("test reset values done");
    for (int c = 0; c < 5; c++) begin
      act = (c == 1 || c >= 3);
      lane_wr(1, {1'b0, 3'(c), 4'h0});
      pin(1, ~act);
      cyc(6);
      wr(`OFS_CLEAR, 32'h1);
      cyc(2);
      chk(wake_request_o[1], 32'h0, "disabled");
      lane_wr(1, {1'b0, 3'(c), 4'h1});
      cyc(6);
      chk(wake_request_o[1], 32'h0, "idle");
      pin(1, act);
      wait_req(1, 1'b1);
      chk(wake_request_o[1], 32'h1, "mode fire");
      if (c == 4) begin
        rd_chk(`OFS_MODE_A, 32'h2020_4520);
        pin(1, 1'b0);
        cyc(6);
        rd_chk(`OFS_MODE_A, 32'h2020_4d20);
      end else begin
        pin(1, ~act);
      end
      cyc(6);
      wr(`OFS_CLEAR, 32'h1);
      chk(wake_request_o[1], 32'h0, "mode clear");
      if (c == 4) rd_chk(`OFS_MODE_A, 32'h2020_4120);
      // drop the enable alone so the next detect write changes one field
      lane_wr(1, {1'b0, 3'(c), 4'h0});
    end
    lane_wr(1, 8'h20);
    $display("test detection modes done");
    // start from a clean status so each source shows only its own bit
    wr(`OFS_IRQ_STAT, 32'h3f);
    rd_chk(`OFS_IRQ_STAT, 32'h0);
    for (int s = 0; s < 6; s++) begin
      code = (s == 5) ? 3'h2 : 3'h3;
      act = (s != 5);
      lane_wr(s, {1'b0, code, 4'h0});
      lane_wr(s, {1'b0, code, 4'h1});
      cyc(6);
      chk(wake_request_o[s], 32'h0, "src idle");
      pin(s, act);
      wait_req(s, 1'b1);
      chk(wake_request_o[s], 32'h1, "src fire");
      cyc(2);
      chk(irq_o, 32'h0, "masked irq");
      rd_chk(`OFS_IRQ_STAT, 32'h1 << s);
      chk(rd_val[s], 32'h1, "status");
      wr(`OFS_IRQ_MASK, 32'h1 << s);
      cyc(2);
      chk(irq_o, 32'h1, "irq");
      wr(`OFS_CLEAR, 32'h6);
      chk(wake_request_o[s], 32'h1, "bad code");
      wr(`OFS_CLEAR, 32'(s));
      chk(wake_request_o[s], 32'h0, "src clear");
      wr(`OFS_IRQ_STAT, 32'h1 << s);
      cyc(2);
      chk(irq_o, 32'h0, "irq clear");
      wr(`OFS_IRQ_MASK, 32'h0);
      pin(s, ~act);
    end
    pin(5, 1'b0);
    wait_req(5, 1'b1);
    chk(wake_request_o[5], 32'h1, "rtc fire");
    lane_wr(5, 8'h20);
    wr(`OFS_CLEAR, 32'h5);
    chk(wake_request_o[5], 32'h0, "rtc clear disabled");
    rd_chk(`OFS_CLEAR, 32'h0);
    $display("test sources done");
    @(posedge sys_clk_i);
    wdt_cmd <= 1'b1;
    @(posedge sys_clk_i);
    wdt_cmd <= 1'b0;
    cyc(2);
    rd_chk(`OFS_RST_FLAGS, 32'h5);
    wr(`OFS_RST_FLAGS, 32'h4);
    rd_chk(`OFS_RST_FLAGS, 32'h4);
    wr(`OFS_CORE_CTRL, 32'h0000_0004);
    chk(system_reset_request_o, 32'h0, "no key");
    for (int r = 0; r < 2; r++) begin
      wr(`OFS_CORE_CTRL, 32'h05fa_0004);
      chk(system_reset_request_o, 32'h1, "sys req");
      if (r == 0) rd_chk(`OFS_CORE_CTRL, 32'hfa05_0004);
      for (int k = 0; k < 12 && system_reset_request_o !== 1'b0; k++)
        cyc(1);
      chk(system_reset_request_o, 32'h0, "req cleared");
      rd_chk(`OFS_RST_FLAGS, r == 0 ? 32'h14 : 32'h10);
      wr(`OFS_RST_FLAGS, 32'h0);
      rd_chk(`OFS_RST_FLAGS, 32'h0);
      @(posedge sys_clk_i);
      slow <= 1'b0;
    end
    wr(`OFS_CORE_CTRL, 32'h05fa_0002);
    chk(active_vector_clear_o, 32'h1, "vclr");
    cyc(1);
    chk(active_vector_clear_o, 32'h0, "vclr self");
    rd_chk(`OFS_CORE_CTRL, 32'hfa05_0000);
    $display("test reset cause done");
    finish_test();
  end
endmodule : standby_wake_reset_flags_bench
`default_nettype wire

// ==== sim/wake_far_side.sv ====
// far side model: wake pins, watchdog event, reset generator answer
// assumes the bench sets pin levels and commands at rising edges
`timescale 1ns/1ps
`default_nettype none
module wake_far_side (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // bench commands
  input wire logic [5:0] pin_level_i,
  input wire logic wdt_cmd_i,
  input wire logic slow_i,
  input wire logic system_reset_request_i,
  // toward the block
  output logic low_voltage_wake_o,
  output logic [3:0] ext_wake_o,
  output logic calendar_wake_o,
  output logic watchdog_reset_o,
  output logic system_reset_done_o
);
  logic wdt_q;
  logic [3:0] cnt;
  assign low_voltage_wake_o = pin_level_i[0];
  assign ext_wake_o = pin_level_i[4:1];
  assign calendar_wake_o = pin_level_i[5];
  // one pulse per command; the reset generator answers late or soon
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdt_q <= 1'b0;
      watchdog_reset_o <= 1'b0;
      cnt <= 4'h0;
      system_reset_done_o <= 1'b0;
    end else begin
      wdt_q <= wdt_cmd_i;
      watchdog_reset_o <= wdt_cmd_i & ~wdt_q;
      if (system_reset_done_o) begin
        system_reset_done_o <= 1'b0;
        cnt <= 4'h0;
      end else if (system_reset_request_i) begin
        if (cnt == (slow_i ? 4'h6 : 4'h1))
          system_reset_done_o <= 1'b1;
        else
          cnt <= cnt + 4'h1;
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule : wake_far_side
`default_nettype wire

// ==== verilog/reset_cause.sv ====
// sticky reset cause flags, cleared only by software writing 0
// assumes cause events are one-cycle pulses on sys_clk_i
`include "wake_params.svh"
`timescale 1ns/1ps
`default_nettype none
module reset_cause (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // cause events
  input wire logic watchdog_evt_i,
  input wire logic soft_evt_i,
  // software write
  input wire logic wr_i,
  input wire logic [`FLAG_W-1:0] wdata_i,
  // flags
  output logic [`FLAG_W-1:0] flags_o
);
  logic [`FLAG_W-1:0] flags, keep, sets, next_flags;

  always_comb begin
    sets = '0;
    sets[`FLAG_WDT] = watchdog_evt_i; // R10
    sets[`FLAG_SOFT] = soft_evt_i; // R9
    keep = wr_i ? wdata_i : `FLAG_MASK; // R11
    // an event in the clearing cycle still sets its flag
    next_flags = ((flags & keep) | sets) & `FLAG_MASK;
  end

  // the block reset stands for the pin reset, so pin flag comes up set
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags <= `FLAGS_RESET; // R10
    end else begin
      flags <= next_flags;
    end
  end

  assign flags_o = flags;

  property p_wdt_set;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    watchdog_evt_i |=> flags[`FLAG_WDT];
  endproperty
  a_wdt_set: assert property (p_wdt_set) // R10
    else $error("watchdog flag not set");

  property p_soft_set;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    soft_evt_i |=> flags[`FLAG_SOFT];
  endproperty
  a_soft_set: assert property (p_soft_set) // R9
    else $error("soft reset flag not set");

  property p_flag_sticky;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    flags[`FLAG_PIN] && !(wr_i && !wdata_i[`FLAG_PIN])
    |=> flags[`FLAG_PIN];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // R11
    else $error("pin flag cleared without a write of 0");
endmodule : reset_cause
`default_nettype wire

// ==== verilog/standby_wake_reset_flags.sv ====
// standby wake request sources, reset cause flags, core reset control
// assumes a single-cycle strobe register port on sys_clk_i
//
// Summary of operation
// R1: detect field 000 low, 001 high, 010 fall, 011 rise, 100 both.
// R2: one byte lane per source: detect 6-4, record 3-2, enable 0.
// R3: read-only record 01 rising, 10 falling, 11 both; both mode only.
// R4: a clear command also clears the source's edge record.
// R5: software sets detect first, enable in a later separate write.
// R6: software programs the voltage detector source to rising only.
// R7: software programs the calendar source to falling only.
// R8: 5-bit write-only clear code 0..5 selects a source; reads zero.
// R9: soft reset flag, bit 4, set by reset from the request bit.
// R10: watchdog flag bit 2 and pin flag bit 0 record their resets.
// R11: reset flags stay set until software writes zero to them.
// R12: request bit 2 asks for a whole-device reset, cleared by it.
// R13: vector clear bit 1 discards active state and self-clears.
// R14: byte order bit 15 reads 0, little endian only.
// R15: enabled source meeting its condition latches a pending request.
// R16: inputs sampled on the block clock; edges from two samples.
`include "wake_params.svh"
`timescale 1ns/1ps
`default_nettype none
module standby_wake_reset_flags (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // wake inputs
  input wire logic low_voltage_wake_i,
  input wire logic [3:0] ext_wake_i,
  input wire logic calendar_wake_i,
  // reset events from the reset generator
  input wire logic watchdog_reset_i,
  input wire logic system_reset_done_i,
  // outputs
  output logic [`NUM_SRC-1:0] wake_request_o,
  output logic irq_o,
  output logic system_reset_request_o,
  output logic active_vector_clear_o
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [`ADDR_W-1:0] mode_addr(input int i);
    mode_addr = (i < `SRC_PER_REG) ? `OFS_MODE_A : `OFS_MODE_B;
  endfunction : mode_addr

  function automatic logic [`LANE_W-1:0] lane_of(
    input logic [31:0] w, input int i);
    lane_of = w[(i % `SRC_PER_REG) * `LANE_W +: `LANE_W];
  endfunction : lane_of

  // ****************************************
  // state
  // ****************************************
  logic [2:0] det [`NUM_SRC];
  logic [2:0] next_det [`NUM_SRC];
  logic [`NUM_SRC-1:0] en, next_en, clr;
  logic [`NUM_SRC-1:0] pend, fire;
  logic [1:0] rec [`NUM_SRC];
  logic [`NUM_SRC-1:0] irq_stat, next_irq_stat;
  logic [`NUM_SRC-1:0] irq_mask, next_irq_mask;
  logic srst_req, next_srst_req;
  logic vclr, next_vclr;
  logic [31:0] rdata, next_rdata;
  logic [`NUM_SRC-1:0] wake_in;
  logic [`FLAG_W-1:0] flags;
  logic key_ok, ctl_wr, soft_evt;

  assign wake_in = {calendar_wake_i, ext_wake_i, low_voltage_wake_i};

  // ****************************************
  // wake sources
  // ****************************************
  wake_src_if src_if [`NUM_SRC] ();

  for (genvar g = 0; g < `NUM_SRC; g++) begin : g_src
    assign src_if[g].detect = det[g];
    assign src_if[g].enable = en[g];
    assign src_if[g].clear = clr[g];
    assign pend[g] = src_if[g].pending;
    assign fire[g] = src_if[g].fire;
    assign rec[g] = src_if[g].record;
    wake_detector u_det (
      .sys_clk_i (sys_clk_i),
      .arst_n_i (arst_n_i),
      .wake_in_i (wake_in[g]),
      .port_if (src_if[g])
    );
  end

  // ****************************************
  // reset cause flags
  // ****************************************
  // the soft flag marks a reset that this request caused
  assign soft_evt = system_reset_done_i & srst_req; // R9

  reset_cause u_cause (
    .sys_clk_i (sys_clk_i),
    .arst_n_i (arst_n_i),
    .watchdog_evt_i (watchdog_reset_i),
    .soft_evt_i (soft_evt),
    .wr_i (wr_i && addr_i == `OFS_RST_FLAGS),
    .wdata_i (wdata_i[`FLAG_W-1:0]),
    .flags_o (flags)
  );

  // ****************************************
  // register writes
  // ****************************************
  // core control needs the key, like the core's own register
  assign key_ok = wdata_i[31:`KEY_LSB] == `KEY_WRITE;
  assign ctl_wr = wr_i && addr_i == `OFS_CORE_CTRL && key_ok;

  always_comb begin
    logic [`LANE_W-1:0] lane;
    lane = '0;
    next_en = en;
    clr = '0;
    for (int i = 0; i < `NUM_SRC; i++) begin
      lane = lane_of(wdata_i, i);
      next_det[i] = det[i];
      if (wr_i && addr_i == mode_addr(i)) begin
        next_det[i] = lane[`DET_MSB:`DET_LSB]; // R2
        next_en[i] = lane[`EN_BIT]; // R2
      end
      // codes 6 and up match no source and are ignored
      if (wr_i && addr_i == `OFS_CLEAR &&
          wdata_i[`CLR_MSB:0] == 5'(i)) begin
        clr[i] = 1'b1; // R8
      end
    end
  end

  always_comb begin
    next_irq_stat = fire | irq_stat;
    if (wr_i && addr_i == `OFS_IRQ_STAT) begin
      next_irq_stat = fire | (irq_stat & ~wdata_i[`NUM_SRC-1:0]);
    end
    next_irq_mask = irq_mask;
    if (wr_i && addr_i == `OFS_IRQ_MASK) begin
      next_irq_mask = wdata_i[`NUM_SRC-1:0];
    end
    // held until the reset it asked for has been applied
    next_srst_req = srst_req & ~system_reset_done_i; // R12
    if (ctl_wr && wdata_i[`CTL_SRST]) begin
      next_srst_req = 1'b1; // R12
    end
    next_vclr = ctl_wr & wdata_i[`CTL_VCLR]; // R13
  end

  // ****************************************
  // register reads
  // ****************************************
  always_comb begin
    next_rdata = '0;
    if (rd_i) begin
      if (addr_i == `OFS_MODE_A || addr_i == `OFS_MODE_B) begin
        if (addr_i == `OFS_MODE_B) begin
          next_rdata = `MODE_B_HI;
        end
        for (int i = 0; i < `NUM_SRC; i++) begin
          if (addr_i == mode_addr(i)) begin
            next_rdata[(i % `SRC_PER_REG) * `LANE_W +: `LANE_W] =
              {1'b0, det[i], rec[i], 1'b0, en[i]}; // R2
          end
        end
      end else if (addr_i == `OFS_RST_FLAGS) begin
        next_rdata[`FLAG_W-1:0] = flags;
      end else if (addr_i == `OFS_CORE_CTRL) begin
        next_rdata[31:`KEY_LSB] = `KEY_READ;
        next_rdata[`CTL_ENDIAN] = 1'b0; // R14
        next_rdata[`CTL_SRST] = srst_req;
      end else if (addr_i == `OFS_IRQ_STAT) begin
        next_rdata[`NUM_SRC-1:0] = irq_stat;
      end else if (addr_i == `OFS_IRQ_MASK) begin
        next_rdata[`NUM_SRC-1:0] = irq_mask;
      end
      // clear register and unmapped addresses read zero
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < `NUM_SRC; i++) begin
        det[i] <= `DET_RESET;
      end
      en <= '0;
      irq_stat <= '0;
      irq_mask <= '0;
      srst_req <= 1'b0;
      vclr <= 1'b0;
      rdata <= '0;
    end else begin
      for (int i = 0; i < `NUM_SRC; i++) begin
        det[i] <= next_det[i];
      end
      en <= next_en;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      srst_req <= next_srst_req;
      vclr <= next_vclr;
      rdata <= next_rdata;
    end
  end

  assign rdata_o = rdata;
  assign wake_request_o = pend;
  assign irq_o = |(irq_stat & irq_mask);
  assign system_reset_request_o = srst_req;
  assign active_vector_clear_o = vclr;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_pend_hold;
    pend[0] && !(wr_i && addr_i == `OFS_CLEAR &&
      wdata_i[`CLR_MSB:0] == `CLR_LVD) |=> pend[0];
  endproperty
  a_pend_hold: assert property (p_pend_hold) // R15
    else $error("pending request lost without clear");

  property p_rtc_clear;
    wr_i && addr_i == `OFS_CLEAR && !en[5] &&
      wdata_i[`CLR_MSB:0] == `CLR_RTC |=> !pend[5] && rec[5] == 2'h0;
  endproperty
  a_rtc_clear: assert property (p_rtc_clear) // R8
    else $error("clear code did not clear source");

  property p_level_high;
    (en[1] && det[1] == wake_pkg::det_high && ext_wake_i[0]) [*3]
    |=> pend[1];
  endproperty
  a_level_high: assert property (p_level_high) // R1
    else $error("high level not latched");

  property p_mode_read;
    rd_i && addr_i == `OFS_MODE_A
    |=> rdata_o[14:12] == $past(det[1]) && rdata_o[7] == 1'b0;
  endproperty
  a_mode_read: assert property (p_mode_read) // R2
    else $error("mode lane read wrong");

  property p_endian;
    rd_i && addr_i == `OFS_CORE_CTRL
    |=> !rdata_o[`CTL_ENDIAN] && rdata_o[31:`KEY_LSB] == `KEY_READ;
  endproperty
  a_endian: assert property (p_endian) // R14
    else $error("byte order bit not little endian");

  property p_vclr;
    ctl_wr && wdata_i[`CTL_VCLR] ##1 !ctl_wr
    |-> active_vector_clear_o ##1 !active_vector_clear_o;
  endproperty
  a_vclr: assert property (p_vclr) // R13
    else $error("vector clear not a single pulse");

  property p_srst;
    ctl_wr && wdata_i[`CTL_SRST] |=> system_reset_request_o;
  endproperty
  a_srst: assert property (p_srst) // R12
    else $error("system reset request not raised");

  property p_srst_hold;
    system_reset_request_o && !system_reset_done_i
    |=> system_reset_request_o;
  endproperty
  a_srst_hold: assert property (p_srst_hold) // R12
    else $error("system reset request dropped early");

  property p_clr_reads_zero;
    rd_i && addr_i == `OFS_CLEAR |=> rdata_o == 32'h0;
  endproperty
  a_clr_reads_zero: assert property (p_clr_reads_zero) // R8
    else $error("clear register not read as zero");

  c_wake: cover property (!pend[2] ##1 pend[2]);
  c_irq: cover property (!irq_o ##1 irq_o);
  c_srst: cover property (system_reset_request_o ##1 system_reset_done_i);
endmodule : standby_wake_reset_flags
`default_nettype wire

// ==== verilog/wake_detector.sv ====
// one wake source: input synchroniser, detection, pending latch
// assumes wake_in_i is asynchronous to sys_clk_i
`include "wake_params.svh"
`timescale 1ns/1ps
`default_nettype none
module wake_detector (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // wake input pin
  input wire logic wake_in_i,
  // control side
  wake_src_if.src port_if
);
  logic sync_a, sync_b, prev, pending, fire;
  logic [1:0] record;
  logic rise, fall, hit;
  logic next_pending, next_fire;
  logic [1:0] next_record;

  always_comb begin
    rise = sync_b & ~prev; // R16
    fall = ~sync_b & prev; // R16
    case (port_if.detect) // R1
      wake_pkg::det_low: hit = ~sync_b;
      wake_pkg::det_high: hit = sync_b;
      wake_pkg::det_fall: hit = fall;
      wake_pkg::det_rise: hit = rise;
      wake_pkg::det_both: hit = rise | fall;
      default: hit = 1'b0;
    endcase
    hit = hit & port_if.enable;
    // set wins over a clear in the same cycle
    next_pending = hit | (pending & ~port_if.clear); // R15
    next_record = record & {2{~port_if.clear}}; // R4
    if (hit && port_if.detect == wake_pkg::det_both) begin
      next_record = next_record | (rise ? `REC_RISE : `REC_FALL); // R3
    end
    next_fire = hit;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
      pending <= 1'b0;
      fire <= 1'b0;
      record <= 2'h0;
    end else begin
      sync_a <= wake_in_i;
      sync_b <= sync_a;
      prev <= sync_b;
      pending <= next_pending;
      fire <= next_fire;
      record <= next_record;
    end
  end

  assign port_if.pending = pending;
  assign port_if.fire = fire;
  assign port_if.record = record;

  property p_rise_latch;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    port_if.enable && port_if.detect == wake_pkg::det_rise && rise
    |=> pending && fire;
  endproperty
  a_rise_latch: assert property (p_rise_latch) // R16
    else $error("rising edge not latched");

  property p_both_record;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    port_if.enable && port_if.detect == wake_pkg::det_both && fall
    |=> record[1];
  endproperty
  a_both_record: assert property (p_both_record) // R3
    else $error("falling edge not recorded");

  c_both_edges: cover property (@(posedge sys_clk_i) record == 2'h3);
endmodule : wake_detector
`default_nettype wire

// ==== verilog/wake_params.svh ====
// constants of the standby wake and reset cause block
// assumes inclusion by bare name from the design files
`ifndef WAKE_PARAMS_SVH
`define WAKE_PARAMS_SVH
`define ADDR_W 8
`define OFS_MODE_A 8'h00
`define OFS_MODE_B 8'h04
`define OFS_CLEAR 8'h08
`define OFS_RST_FLAGS 8'h0c
`define OFS_CORE_CTRL 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_MASK 8'h18
`define NUM_SRC 6
`define SRC_PER_REG 4
`define LANE_W 8
`define DET_MSB 6
`define DET_LSB 4
`define REC_MSB 3
`define REC_LSB 2
`define EN_BIT 0
`define DET_RESET 3'h2
`define REC_RISE 2'h1
`define REC_FALL 2'h2
`define CLR_MSB 4
`define CLR_LVD 5'h00
`define CLR_EXT0 5'h01
`define CLR_RTC 5'h05
`define FLAG_W 5
`define FLAG_PIN 0
`define FLAG_WDT 2
`define FLAG_SOFT 4
`define FLAG_MASK 5'h15
`define FLAGS_RESET 5'h01
`define CTL_VCLR 1
`define CTL_SRST 2
`define CTL_ENDIAN 15
`define KEY_LSB 16
`define KEY_WRITE 16'h05fa
`define KEY_READ 16'hfa05
`define MODE_B_HI 32'h2020_0000
`endif

// ==== verilog/wake_pkg.sv ====
// types of the standby wake and reset cause block
// assumes nothing beyond a SystemVerilog compiler
package wake_pkg;
  // detection codes 101 to 111 are not permitted
  typedef enum logic [2:0] {
    det_low, det_high, det_fall, det_rise, det_both
  } detect_type;
endpackage : wake_pkg

// ==== verilog/wake_src_if.sv ====
// interface between the register block and one wake source
// assumes the control side drives mode and clear on sys_clk_i
`timescale 1ns/1ps
`default_nettype none
interface wake_src_if;
  logic [2:0] detect;
  logic enable;
  logic clear;
  logic pending;
  logic fire;
  logic [1:0] record;
  modport ctl (output detect, output enable, output clear,
               input pending, input fire, input record);
  modport src (input detect, input enable, input clear,
               output pending, output fire, output record);
endinterface : wake_src_if
`default_nettype wire
